/* src/qdsc_pkg.sv */
/*
 * package for the quad dac serial command decoder: command word layout,
 * command codes, address codes, timing counts.
 * assumes a 20 MHz system clock; the serial link is sampled by it.
 */
// Overview of operation
// - eight-bit operating state, live and stored; upper nibble mute, lower shutdown
// - power-up loads live operating state from stored copy; later loadable both ways
// - command word is 14 bits, MSB first: start, two control, three address, data
// - control 00 address 0-3 stores payload into that DAC's stored register
// - control 00 address 4 stores payload into stored operating state
// - control 01 address 0-3 writes live DAC register, updating only that output
// - control 01 address 4 writes live operating state, applied to every output
// - control 10 address 0-4 shifts selected stored register out; nothing else changes
// - control 11 address 0-3 copies stored DAC value into live, updating that output
// - control 11 address 4 copies stored operating state into live state
// - incoming bits shift into a 14-bit register, most significant first
// - data input sampled on serial clock rising edges only while select is low
// - select high ignores the link and holds serial output unchanged
// - serial output stays undriven until a valid read command and address arrive
// - serial output shifts in the same clocks in which input bits arrive
// - ready flag output reflects nonvolatile memory status
// - read data goes out in eight clocks after last address bit; released on select high
// - store holds ready flag low until done; host waits for it
// - power-up mutes outputs, disables link, loads DACs then state, then enables
package qdsc_pkg;
    localparam int WORD_BITS = 14;
    localparam int HEAD_BITS = 6;
    localparam int DATA_BITS = 8;
    localparam int NUM_DAC = 4;
    localparam int ADDR_STATE = 4;
    localparam logic [1:0] CMD_STORE = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_LOAD = 2'h3;
    localparam logic [2:0] ADDR_OPSTATE = 3'h4;
    localparam logic [7:0] NV_RESET = 8'h00;
    localparam logic [7:0] ALL_OFF = 8'hFF;
    localparam int CLK_HZ = 20000000;
    localparam int STORE_TIME_US = 13000;
    localparam int STORE_CYCLES = STORE_TIME_US * (CLK_HZ / 1000000);
    localparam int INIT_TIME_US = 80;
    localparam int INIT_CYCLES = INIT_TIME_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 19;
endpackage : qdsc_pkg

/* src/qdsc_sync.sv */
/*
 * two flip-flop synchroniser for one pin level.
 * assumes the input is asynchronous to i_clk.
 */
`timescale 1ns/10ps
module qdsc_sync
#(
    parameter logic INIT = 1'b0 // idle level of the pin, held through reset
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_pin,
    output logic o_level
);
    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_q <= INIT;
            o_level <= INIT;
        end
        else
        begin
            meta_q <= i_pin;
            o_level <= meta_q;
        end
    end
endmodule : qdsc_sync

/* src/qdsc_top.sv */
/*
 * serial command decoder: link receiver, command execution, stored and live
 * registers, power-up loader and store timer.
 * assumes select, serial clock and data arrive from outside the clock domain.
 */
`timescale 1ns/10ps
module qdsc_top
    import qdsc_pkg::*;
#(
    parameter int STORE_CNT = STORE_CYCLES,
    parameter int INIT_CNT = INIT_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sel_n,
    input wire logic i_sclk,
    input wire logic i_sdata,
    output logic o_sdata,
    output logic o_sdata_oe,
    output logic o_memory_ready_flag,
    output logic [31:0] o_dac_code,
    output logic [3:0] o_mute,
    output logic [3:0] o_shutdown
);
    // ***********************************************************
    // synchronised link pins
    // ***********************************************************
    logic sel_n_s;
    logic sclk_s;
    logic sdata_s;
    logic sclk_prev_q;

    qdsc_sync #(.INIT(1'b1)) u_sync_sel (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(i_sel_n), .o_level(sel_n_s));
    qdsc_sync #(.INIT(1'b0)) u_sync_clk (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(i_sclk), .o_level(sclk_s));
    qdsc_sync #(.INIT(1'b0)) u_sync_dat (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(i_sdata), .o_level(sdata_s));

    typedef enum logic [1:0] {QDSC_INIT, QDSC_IDLE, QDSC_STORE} qdsc_state_e;
    qdsc_state_e state_q;

    logic [WORD_BITS-1:0] shift_q;
    logic [3:0] count_q;
    logic [7:0] nv_q [0:NUM_DAC];
    logic [7:0] live_q [0:NUM_DAC-1];
    logic [7:0] opstate_q;
    logic [7:0] tx_q;
    logic [CNT_W-1:0] timer_q;
    logic [2:0] init_idx_q;
    logic pend_q;
    logic [1:0] pend_cmd_q;
    logic [2:0] pend_addr_q;
    logic [7:0] pend_data_q;

    // ***********************************************************
    // decode of the incoming word
    // ***********************************************************
    // link stays live during a store so the payload byte behind the header can arrive
    wire link_on = (state_q != QDSC_INIT) && !sel_n_s;
    wire rise = link_on && sclk_s && !sclk_prev_q;
    wire fall = link_on && !sclk_s && sclk_prev_q;
    wire [WORD_BITS-1:0] next_word = {shift_q[WORD_BITS-2:0], sdata_s};
    wire head_done = rise && (count_q == 4'(HEAD_BITS - 1));
    wire word_done = rise && (count_q == 4'(WORD_BITS - 1));
    wire [1:0] h_cmd = next_word[4:3];
    wire [2:0] h_addr = next_word[2:0];
    wire h_valid = next_word[5] && (h_addr <= ADDR_OPSTATE);
    wire [1:0] w_cmd = next_word[12:11];
    wire [2:0] w_addr = next_word[10:8];
    wire [7:0] w_data = next_word[7:0];
    wire w_valid = next_word[13] && (w_addr <= ADDR_OPSTATE);
    // store refused when every output is muted or shut down
    wire all_off = ((opstate_q[7:4] | opstate_q[3:0]) == 4'hF);

    // ***********************************************************
    // serial receiver and transmitter
    // ***********************************************************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sclk_prev_q <= 1'b0;
            shift_q <= '0;
            count_q <= '0;
            tx_q <= '0;
            o_sdata <= 1'b0;
            o_sdata_oe <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            if (sel_n_s)
            begin
                count_q <= '0;
                o_sdata_oe <= 1'b0;
            end
            else if (rise)
            begin
                shift_q <= next_word;
                count_q <= word_done ? 4'h0 : count_q + 4'h1;
                if (head_done && h_valid && h_cmd == CMD_READ)
                begin
                    tx_q <= nv_q[h_addr];
                    o_sdata_oe <= 1'b1;
                end
            end
            else if (fall && o_sdata_oe)
            begin
                o_sdata <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // ***********************************************************
    // registers, power-up loader and store timer
    // ***********************************************************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= QDSC_INIT;
            timer_q <= '0;
            init_idx_q <= '0;
            for (int i = 0; i <= NUM_DAC; i++)
                nv_q[i] <= NV_RESET;
            for (int i = 0; i < NUM_DAC; i++)
                live_q[i] <= '0;
            opstate_q <= ALL_OFF;
            pend_q <= 1'b0;
            pend_cmd_q <= '0;
            pend_addr_q <= '0;
            pend_data_q <= '0;
        end
        else
        begin
            unique case (state_q)
                QDSC_INIT:
                begin
                    // dac registers first, operating state last
                    if (timer_q < CNT_W'(INIT_CNT))
                        timer_q <= timer_q + 1'b1;
                    else if (init_idx_q < 3'(NUM_DAC))
                    begin
                        live_q[init_idx_q[1:0]] <= nv_q[init_idx_q];
                        init_idx_q <= init_idx_q + 3'h1;
                    end
                    else
                    begin
                        opstate_q <= nv_q[ADDR_STATE];
                        timer_q <= '0;
                        state_q <= QDSC_IDLE;
                    end
                end
                QDSC_IDLE:
                begin
                    if (head_done && h_valid && h_cmd == CMD_STORE && !all_off)
                    begin
                        state_q <= QDSC_STORE;
                        timer_q <= '0;
                        pend_q <= 1'b0;
                    end
                    if (word_done && w_valid)
                    begin
                        unique case (w_cmd)
                            CMD_WRITE:
                                if (w_addr == ADDR_OPSTATE)
                                    opstate_q <= w_data;
                                else
                                    live_q[w_addr[1:0]] <= w_data;
                            CMD_LOAD:
                                if (w_addr == ADDR_OPSTATE)
                                    opstate_q <= nv_q[ADDR_STATE];
                                else
                                    live_q[w_addr[1:0]] <= nv_q[w_addr];
                            default:
                            begin
                            end
                        endcase
                    end
                end
                QDSC_STORE:
                begin
                    // capture the payload, then commit once the store time has run
                    if (word_done && !pend_q)
                    begin
                        pend_q <= 1'b1;
                        pend_cmd_q <= w_cmd;
                        pend_addr_q <= w_addr;
                        pend_data_q <= w_data;
                    end
                    if (timer_q < CNT_W'(STORE_CNT))
                        timer_q <= timer_q + 1'b1;
                    else
                    begin
                        if (pend_q && pend_cmd_q == CMD_STORE)
                            nv_q[pend_addr_q] <= pend_data_q;
                        pend_q <= 1'b0;
                        state_q <= QDSC_IDLE;
                    end
                end
                default:
                    state_q <= QDSC_INIT;
            endcase
        end
    end

    // ***********************************************************
    // outputs to the analog side
    // ***********************************************************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_dac_code <= '0;
            o_mute <= 4'hF;
            o_shutdown <= 4'h0;
            o_memory_ready_flag <= 1'b0;
        end
        else
        begin
            o_dac_code <= {live_q[3], live_q[2], live_q[1], live_q[0]};
            o_mute <= (state_q == QDSC_INIT) ? 4'hF : opstate_q[7:4];
            o_shutdown <= (state_q == QDSC_INIT) ? 4'h0 : opstate_q[3:0];
            o_memory_ready_flag <= (state_q == QDSC_IDLE);
        end
    end

    // ***********************************************************
    // assertions
    // ***********************************************************
    property p_mute_init;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_q == QDSC_INIT) |=> (o_mute == 4'hF);
    endproperty
    a_mute_init: assert property (p_mute_init) else $error("outputs not muted during init");

    property p_oe_idle;
        @(posedge i_clk) disable iff (!i_rstn)
        sel_n_s |=> !o_sdata_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("serial output driven while deselected");

    property p_hold_out;
        @(posedge i_clk) disable iff (!i_rstn)
        sel_n_s |=> $stable(o_sdata);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("serial output moved while deselected");

    property p_oe_read;
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(o_sdata_oe) |-> $past(head_done) && $past(h_cmd) == CMD_READ;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("serial output enabled without read");

    property p_busy;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_q == QDSC_STORE) |=> !o_memory_ready_flag;
    endproperty
    a_busy: assert property (p_busy) else $error("ready flag high during store");

    property p_write_dac;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_q == QDSC_IDLE && word_done && w_valid && w_cmd == CMD_WRITE && w_addr == 3'h0)
            |=> live_q[0] == $past(w_data);
    endproperty
    a_write_dac: assert property (p_write_dac) else $error("dac 0 write lost");

    property p_write_state;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_q == QDSC_IDLE && word_done && w_valid && w_cmd == CMD_WRITE && w_addr == ADDR_OPSTATE)
            |=> ##1 o_mute == $past(w_data, 2) >> 4;
    endproperty
    a_write_state: assert property (p_write_state) else $error("state write not applied");

    property p_bad_addr;
        @(posedge i_clk) disable iff (!i_rstn)
        (word_done && !w_valid) |=> $stable(opstate_q);
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("invalid word changed state");

    property p_sample;
        @(posedge i_clk) disable iff (!i_rstn)
        (sel_n_s && state_q == QDSC_IDLE) |=> count_q == 4'h0;
    endproperty
    a_sample: assert property (p_sample) else $error("bits counted while deselected");
endmodule : qdsc_top

/* tb/qdsc_host.sv */
/*
 * host model for the serial link: drives select, link clock and data.
 * assumes i_clk comes from the bench; signals move on falling i_clk.
 */
`timescale 1ns/10ps
module qdsc_host
(
    input wire logic i_clk,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_sel_n,
    output logic o_sclk,
    output logic o_sdata
);
    // ****************************
    // link host
    // ****************************
    // idle levels at time zero
    initial
    begin
        o_sel_n = 1'b1;
        o_sclk = 1'b0; // clock rests low between words
        o_sdata = 1'b0;
    end
    // one half period of the 400 ns link clock
    task automatic half();
        repeat (4) @(negedge i_clk);
    endtask : half
    // send one word msb first, sampling the return line mid high phase
    task automatic xfer(input logic [13:0] w, input logic en, output logic [7:0] rd);
        logic pin;
        o_sel_n = !en;
        half(); // select leads the first rise by 400 ns
        for (int i = 13; i >= 0; i--)
        begin
            o_sdata = w[i]; // start, control, address, data
            half();
            o_sclk = 1'b1;
            repeat (2) @(negedge i_clk);
            pin = i_sdo_oe ? i_sdo : 1'bz;
            if (i < 8) rd[i] = pin; // return bits move with input bits
            repeat (2) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        half();
        o_sel_n = 1'b1;
        o_sdata = !o_sdata; // released data line shows no stale value
        half();
    endtask : xfer
endmodule : qdsc_host

/* tb/qdsc_top_tb.sv */
/*
 * self-checking bench for the serial command decoder.
 * assumes the host model drives the link; assertions sit in the design.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module qdsc_top_tb;
    import qdsc_pkg::*;
    typedef struct packed {logic [31:0] c; logic [7:0] s; logic [7:0] r; logic rd; logic rdy;} qdsc_note_s;
    logic clk = 1'b0;
    logic rstn;
    logic sel_n, sclk, sdata, sdo, oe, rdy;
    logic [31:0] code;
    logic [3:0] mute, shut;
    logic [7:0] nv [5];
    logic [7:0] lv [5];
    logic [7:0] rd_got;
    qdsc_note_s note, want;
    qdsc_note_s notes [$];
    int fail_count = 0;
    int total_checks = 0;
    int seed = 32'h2542;
    event done_ev;
    // ****************************
    // design and host
    // ****************************
    qdsc_top #(.STORE_CNT(200), .INIT_CNT(10)) u_qdsc_top (.i_clk(clk), .i_rstn(rstn), .i_sel_n(sel_n),
        .i_sclk(sclk), .i_sdata(sdata), .o_sdata(sdo), .o_sdata_oe(oe), .o_memory_ready_flag(rdy),
        .o_dac_code(code), .o_mute(mute), .o_shutdown(shut));
    qdsc_host u_qdsc_host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(oe), .o_sel_n(sel_n), .o_sclk(sclk),
        .o_sdata(sdata));
    // 20 MHz clock
    always #25 clk = ~clk;
    // verdict and end of run
    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // bounded wait for the ready flag
    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask : wait_ready
    // note the expected outcome, then send the word
    task automatic cmd(input logic st, input logic [1:0] c, input logic [2:0] a, input logic [7:0] d,
                       input logic en);
        logic ok;
        logic busy;
        logic [7:0] rd;
        ok = st && en && (a <= ADDR_OPSTATE); // other words change nothing
        busy = ok && (c == CMD_STORE) && ((lv[4][7:4] | lv[4][3:0]) != 4'hF);
        note.r = 8'h00;
        if (busy) nv[a] = d;
        if (ok && c == CMD_WRITE) lv[a] = d;
        if (ok && c == CMD_LOAD) lv[a] = nv[a];
        if (ok && c == CMD_READ) note.r = nv[a];
        note.c = {lv[3], lv[2], lv[1], lv[0]};
        note.s = lv[4];
        note.rd = ok && (c == CMD_READ);
        note.rdy = !busy;
        notes.push_back(note);
        u_qdsc_host.xfer({st, c, a, d}, en, rd);
        rd_got = rd;
        repeat (2) @(negedge clk);
        ->done_ev;
        if (busy) wait_ready(); // host holds off until the store finishes
    endtask : cmd
    // compare outputs against the oldest note
    always @(done_ev)
    begin
        want = notes.pop_front();
        `CHK(code, want.c)
        `CHK(mute, want.s[7:4])
        `CHK(shut, want.s[3:0])
        `CHK(rdy, want.rdy)
        `CHK(oe, 1'b0)
        if (want.rd) `CHK(rd_got, want.r)
    end
    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        for (int i = 0; i < 5; i++)
        begin
            nv[i] = NV_RESET;
            lv[i] = NV_RESET;
        end
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        `CHK(mute, 4'hF)
        `CHK(rdy, 1'b0)
        rstn = 1'b1;
        wait_ready();
        cmd(1'b1, CMD_WRITE, 3'h7, 8'h5A, 1'b1);
        for (int i = 0; i < 4; i++) cmd(1'b1, CMD_WRITE, 3'(i), 8'($random(seed)), 1'b1);
        cmd(1'b1, CMD_WRITE, ADDR_OPSTATE, 8'($random(seed)) & 8'h33, 1'b1);
        for (int i = 0; i < 5; i++) cmd(1'b1, CMD_STORE, 3'(i), 8'($random(seed)), 1'b1);
        for (int i = 0; i < 5; i++) cmd(1'b1, CMD_READ, 3'(i), 8'($random(seed)), 1'b1);
        for (int i = 0; i < 5; i++) cmd(1'b1, CMD_LOAD, 3'(i), 8'($random(seed)), 1'b1);
        // store refused while every output is off
        cmd(1'b1, CMD_WRITE, ADDR_OPSTATE, ALL_OFF, 1'b1);
        cmd(1'b1, CMD_STORE, 3'h0, 8'hC3, 1'b1);
        cmd(1'b1, CMD_READ, 3'h0, 8'h00, 1'b1);
        cmd(1'b1, CMD_WRITE, ADDR_OPSTATE, 8'h00, 1'b1);
        // bad addresses, zero start bit, select held high
        for (int i = 5; i < 8; i++) cmd(1'b1, CMD_WRITE, 3'(i), 8'hA5, 1'b1);
        cmd(1'b0, CMD_WRITE, 3'h1, 8'h3C, 1'b1);
        cmd(1'b1, CMD_WRITE, 3'h2, 8'h96, 1'b0);
        // second reset clears stored copies to NV_RESET, then reloads live copies from them
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            nv[i] = NV_RESET;
            lv[i] = NV_RESET;
        end
        wait_ready();
        cmd(1'b1, CMD_READ, ADDR_OPSTATE, 8'h00, 1'b1);
        report_and_stop();
    end
endmodule : qdsc_top_tb
